// [pbd_pkg.sv]
// Package for the port B pin data block: register map, reset value, pin function codes and carriers.
// Assumes a 32-bit Avalon-MM slave port with byte enables on the system clock.
package pbd_pkg;

  localparam int PBD_ADDR_W = 28;
  localparam int PBD_DATA_W = 32;
  localparam int PBD_PINS = 16;

  // Printed address of the port B pin data register, a halfword in the upper half of its word.
  localparam logic [27:0] PBD_DATA_ADDR = 28'h5ffffc2;
  localparam logic [27:0] PBD_WORD_ADDR = 28'h5ffffc0;
  localparam int PBD_DATA_LSB = 16;
  localparam logic [15:0] PBD_DATA_RST = 16'h0000;
  localparam logic [31:0] PBD_UNMAPPED_RD = 32'h00000000;

  // Per-pin function codes as driven by the pin function selector.
  localparam logic [1:0] PBD_FN_GPIO = 2'h0;
  localparam logic [1:0] PBD_FN_RSVD = 2'h1;
  localparam logic [1:0] PBD_FN_ALT = 2'h2;
  localparam logic [1:0] PBD_FN_PATTERN = 2'h3;

  typedef struct packed {
    logic [27:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } pbd_req_t;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } pbd_pins_t;

  typedef enum logic [0:0] {
    PBD_IDLE,
    PBD_DONE
  } pbd_state_t;

endpackage

// [pbd_port_b.sv]
// Port B pin data register with its pin drive, as an Avalon-MM slave.
// Assumes direction, function and pattern-enable settings arrive from their own blocks, synchronous to clk.
// Notes on behaviour
// - Sixteen-bit data register, bit n serves pin n.
// - Ordinary output pins drive the stored bit.
// - Output-direction reads return the stored bit.
// - Input-direction reads return the sampled pin level.
// - Input or alternate writes store, pins unaffected.
// - Enabled pattern-output pins ignore data writes.
// - Fixed address, byte, halfword, word access.
// - Power-on reset clears the register to zero.
// - Other resets and low-power modes keep contents.
// - Pin function comes from the external selector.
`timescale 1ns/10ps
module pbd_port_b
  import pbd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [27:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] direction_select_bits,
  input wire logic [31:0] pin_function_selector,
  input wire logic [15:0] next_pattern_enable_reg,
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe
);

  pbd_req_t req;
  pbd_state_t state_q, state_d;
  logic [15:0] data_q, data_d;
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;
  pbd_pins_t pins_q, pins_d;
  logic [15:0] gpio_pin;
  logic [15:0] locked;
  logic [15:0] lane_mask;
  logic hit;

  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 byteenable: avs_byteenable, writedata: avs_writedata};

  // Function code of one pin from the packed selector word.
  function automatic logic [1:0] pin_fn(input logic [31:0] sel, input int idx);
    pin_fn = sel[2 * idx +: 2];
  endfunction

  always_comb begin
    for (int i = 0; i < PBD_PINS; i++) begin
      // The data register only drives pins set to general I/O.
      gpio_pin[i] = (pin_fn(pin_function_selector, i) == PBD_FN_GPIO);
      locked[i] = (pin_fn(pin_function_selector, i) == PBD_FN_PATTERN) && next_pattern_enable_reg[i];
    end
  end

  // Halfword or word accesses to the containing word both reach the register.
  assign hit = (req.address[27:2] == PBD_WORD_ADDR[27:2]);
  // Upper byte lanes of the word carry the halfword at its printed address.
  assign lane_mask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}}};

  // A transfer is answered one cycle after it is seen, which gives read data a clean register stage.
  always_comb begin
    state_d = state_q;
    data_d = data_q;
    rdata_d = rdata_q;
    wait_d = 1'b1;
    case (state_q)
      PBD_IDLE: begin
        if (req.read || req.write) begin
          state_d = PBD_DONE;
          wait_d = 1'b0;
          rdata_d = PBD_UNMAPPED_RD;
          if (hit && req.write) begin
            // Stored regardless of direction; locked pattern bits are left alone.
            data_d = (data_q & ~(lane_mask & ~locked)) |
                     (req.writedata[31:16] & lane_mask & ~locked);
          end else if (hit) begin
            for (int i = 0; i < PBD_PINS; i++) begin
              // Output direction shows the register, input shows the pin.
              rdata_d[PBD_DATA_LSB + i] = direction_select_bits[i] ? data_q[i] : pin_in[i];
            end
          end
        end
      end
      PBD_DONE: begin
        state_d = PBD_IDLE;
      end
      default: begin
        state_d = PBD_IDLE;
      end
    endcase
  end

  always_comb begin
    for (int i = 0; i < PBD_PINS; i++) begin
      // Only ordinary outputs are driven from the register; other pins belong to their own function.
      pins_d.oe[i] = direction_select_bits[i] && gpio_pin[i];
      pins_d.out[i] = pins_d.oe[i] ? data_q[i] : 1'b0;
    end
  end

  // Only rst_n clears the register; a low clk_en, which stands in for the low-power modes, only holds it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= PBD_IDLE;
      data_q <= PBD_DATA_RST;
      rdata_q <= PBD_UNMAPPED_RD;
      wait_q <= 1'b1;
      pins_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      data_q <= data_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
      pins_q <= pins_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign pin_out = pins_q.out;
  assign pin_oe = pins_q.oe;

  a_reset_clears: assert property (@(posedge clk) !rst_n |=> data_q == PBD_DATA_RST)
    else $error("data register not cleared by reset");

  a_locked_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.write && hit) |=> ((data_q & $past(locked)) == ($past(data_q) & $past(locked))))
    else $error("pattern-locked data bit changed on write");

  a_lane_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.write && hit && !req.byteenable[3]) |=> data_q[15:8] == $past(data_q[15:8]))
    else $error("unselected byte lane changed");

  a_write_store: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.write && hit && req.byteenable[2] && locked[7:0] == 8'h00)
    |=> data_q[7:0] == $past(req.writedata[23:16]))
    else $error("write data not stored");

  a_drive_out: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && direction_select_bits[0] && gpio_pin[0]) |=> (pin_oe[0] && pin_out[0] == $past(data_q[0])))
    else $error("ordinary output pin not driven from register");

  a_alt_undriven: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !gpio_pin[1]) |=> !pin_oe[1])
    else $error("alternate function pin driven from register");

  a_read_out: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.read && !req.write && hit && direction_select_bits[2])
    |=> avs_readdata[18] == $past(data_q[2]))
    else $error("output-direction read not from register");

  a_read_in: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.read && !req.write && hit && !direction_select_bits[3])
    |=> avs_readdata[19] == $past(pin_in[3]))
    else $error("input-direction read not from pin");

  a_answer_time: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && (req.read || req.write)) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("transfer not answered in one cycle");

  // Bus answer and read data: one answer cycle per request, and read data stands between answers.
  // The unmapped path answers like a hit, so software probing the map never hangs.
  a_reset_outputs: assert property (@(posedge clk)
    !rst_n
    |=> (avs_waitrequest && avs_readdata == PBD_UNMAPPED_RD && pin_oe == 16'h0000 && pin_out == 16'h0000))
    else $error("outputs not at rest after reset");

  a_reset_idle: assert property (@(posedge clk)
    !rst_n
    |=> state_q == PBD_IDLE)
    else $error("bus state not idle after reset");

  a_take_state: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && (req.read || req.write))
    |=> state_q == PBD_DONE)
    else $error("request not taken from idle");

  a_answer_once: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !avs_waitrequest)
    |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  a_idle_wait: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && !req.read && !req.write)
    |=> avs_waitrequest)
    else $error("answer given without a request");

  a_miss_read: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.read && !req.write && !hit)
    |=> avs_readdata == PBD_UNMAPPED_RD)
    else $error("unmapped read returned data");

  a_miss_write: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.write && !hit)
    |=> $stable(data_q))
    else $error("unmapped write changed the register");

  a_read_word: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.read && !req.write && hit)
    |=> avs_readdata[31:16] == $past((direction_select_bits & data_q) | (~direction_select_bits & pin_in)))
    else $error("read word not per-pin register or pin level");

  a_read_lowzero: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.read && !req.write && hit)
    |=> avs_readdata[15:0] == 16'h0000)
    else $error("lower half of read word not zero");

  a_readdata_stand: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !(state_q == PBD_IDLE && (req.read || req.write)))
    |=> $stable(avs_readdata))
    else $error("read data moved between answers");

  // Register contents: lane writes, pattern bits without an enable, and every path that must leave the value alone.
  a_word_store: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.write && hit && req.byteenable[3:2] == 2'h3 && locked == 16'h0000)
    |=> data_q == $past(req.writedata[31:16]))
    else $error("halfword write not stored");

  a_upper_store: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.write && hit && req.byteenable[3] && locked[15:8] == 8'h00)
    |=> data_q[15:8] == $past(req.writedata[31:24]))
    else $error("upper lane write not stored");

  a_lower_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.write && hit && !req.byteenable[2])
    |=> data_q[7:0] == $past(data_q[7:0]))
    else $error("unselected lower lane changed");

  a_alt_store: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.write && hit && req.byteenable[2]
     && pin_function_selector[1:0] == PBD_FN_ALT)
    |=> data_q[0] == $past(req.writedata[16]))
    else $error("write to alternate function pin not stored");

  a_input_store: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.write && hit && req.byteenable[2]
     && !direction_select_bits[1] && !locked[1])
    |=> data_q[1] == $past(req.writedata[17]))
    else $error("write to input pin not stored");

  a_pattern_store: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && state_q == PBD_IDLE && req.write && hit && req.byteenable[3]
     && pin_function_selector[19:18] == PBD_FN_PATTERN && !next_pattern_enable_reg[9])
    |=> data_q[9] == $past(req.writedata[25]))
    else $error("write to pattern pin without enable not stored");

  a_no_write_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !(state_q == PBD_IDLE && req.write && hit))
    |=> $stable(data_q))
    else $error("register changed without a write");

  // Pin drive: only general I/O outputs are driven, one cycle behind the register and the direction.
  a_oe_map: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en
    |=> pin_oe == $past(direction_select_bits & gpio_pin))
    else $error("pin enables not from direction and function");

  a_out_map: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en
    |=> pin_out == $past(data_q & direction_select_bits & gpio_pin))
    else $error("pin levels not from register");

  a_input_undriven: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && !direction_select_bits[4])
    |=> !pin_oe[4])
    else $error("input pin driven from register");

  a_pattern_undriven: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && pin_function_selector[31:30] == PBD_FN_PATTERN)
    |=> !pin_oe[15])
    else $error("pattern function pin driven from register");

  a_reserved_undriven: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && pin_function_selector[11:10] == PBD_FN_RSVD)
    |=> !pin_oe[5])
    else $error("reserved function pin driven from register");

  a_locked_undriven: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && locked[7])
    |=> !pin_oe[7])
    else $error("locked pattern pin driven from register");

  // A low clock enable stands in for a stopped clock in the low-power modes, so nothing may move.
  a_frozen_data: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_en
    |=> $stable(data_q))
    else $error("register moved while clock enable low");

  a_frozen_pins: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_en
    |=> ($stable(pin_out) && $stable(pin_oe)))
    else $error("pins moved while clock enable low");

  a_frozen_bus: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_en
    |=> ($stable(avs_waitrequest) && $stable(avs_readdata) && $stable(state_q)))
    else $error("bus answer moved while clock enable low");

endmodule

// [pbd_ext_pins.sv]
// Model of the external circuitry wired to the sixteen port B pins.
// Assumes the device's per-pin drive and enable come from registers on the system clock.
`timescale 1ns/10ps
module pbd_ext_pins (
  input wire logic [15:0] ext_val,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  output logic [15:0] pin_in
);
  // Where the device drives a pin the outside yields, so the wire shows the device's level.
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
  end
endmodule

// [tb.sv]
// Self-checking bench for the port B pin data register, driven as an Avalon-MM master.
// Assumes the register sits in bits 31:16 of the word at PBD_WORD_ADDR.
`timescale 1ns/10ps
module tb;
  import pbd_pkg::*;
  logic clk, rst_n, ce, rd, wr, wreq;
  logic [27:0] addr;
  logic [3:0] be;
  logic [31:0] wd, rdata, fn;
  logic [15:0] dir, npe, ext, pin_in, pin_out, pin_oe, v, s;
  logic [31:0] exp_q[$];
  int num_errors, compares, seed, c;

  pbd_port_b DUT (.clk(clk), .rst_n(rst_n), .clk_en(ce), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_byteenable(be), .avs_writedata(wd), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .direction_select_bits(dir), .pin_function_selector(fn),
    .next_pattern_enable_reg(npe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  pbd_ext_pins ext_pins (.ext_val(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  task final_report;
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The request is held until the edge that samples waitrequest low, then dropped.
  task bus(input logic r, input logic [27:0] a, input logic [3:0] b, input logic [31:0] d);
    int n;
    @(posedge clk);
    rd <= r;
    wr <= !r;
    addr <= a;
    be <= b;
    wd <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    if (n == 20) begin
      num_errors++;
      final_report();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task rdx(input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b1, PBD_WORD_ADDR, 4'hf, 32'h00000000);
  endtask

  task cmp_pins(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pins are looked at on the falling edge, where the registered drive has settled.
  task pins(input logic [15:0] eo, input logic [15:0] ee);
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp_pins(pin_out, eo);
    cmp_pins(pin_oe, ee);
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    if (rd && wreq === 1'b0) begin
      cmp(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hxxxxxxxx);
    end
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    {rst_n, rd, wr, addr, be, wd, fn, dir, npe, ext} = '0;
    ce = 1'b1;
    num_errors = 0;
    compares = 0;
    seed = 74;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdx({PBD_DATA_RST, 16'h0000});
    dir <= 16'hffff;
    v = 16'($random(seed));
    bus(1'b0, PBD_WORD_ADDR, 4'hf, {v, 16'h0000});
    rdx({v, 16'h0000});
    pins(v, 16'hffff);
    bus(1'b0, PBD_WORD_ADDR, 4'h4, 32'h005a0000);
    s = {v[15:8], 8'h5a};
    rdx({s, 16'h0000});
    bus(1'b0, PBD_WORD_ADDR, 4'h8, 32'ha5000000);
    rdx({8'ha5, s[7:0], 16'h0000});
    v = 16'($random(seed));
    ext <= v;
    dir <= 16'h0000;
    rdx({v, 16'h0000});
    s = ~v;
    bus(1'b0, PBD_WORD_ADDR, 4'hc, {s, 16'h0000});
    pins(16'h0000, 16'h0000);
    dir <= 16'hffff;
    rdx({s, 16'h0000});
    fn <= 32'hffffffff;
    npe <= 16'h00ff;
    bus(1'b0, PBD_WORD_ADDR, 4'hc, 32'h00000000);
    s = {8'h00, s[7:0]};
    rdx({s, 16'h0000});
    npe <= 16'h0000;
    for (c = 0; c < 4; c++) begin
      fn <= {16{c[1:0]}};
      v = 16'($random(seed));
      bus(1'b0, PBD_WORD_ADDR, 4'hc, {v, 16'h0000});
      rdx({v, 16'h0000});
      pins(c == 0 ? v : 16'h0000, c == 0 ? 16'hffff : 16'h0000);
    end
    // A low clock enable must freeze the pins even though the direction changes underneath.
    fn <= 32'h00000000;
    pins(v, 16'hffff);
    ce <= 1'b0;
    dir <= 16'h0000;
    pins(v, 16'hffff);
    ce <= 1'b1;
    pins(16'h0000, 16'h0000);
    dir <= 16'hffff;
    rdx({v, 16'h0000});
    bus(1'b0, 28'h0000100, 4'hf, 32'hffffffff);
    rdx({v, 16'h0000});
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdx({PBD_DATA_RST, 16'h0000});
    pins(16'h0000, 16'hffff);
    exp_q.push_back(PBD_UNMAPPED_RD);
    bus(1'b1, 28'h0000100, 4'hf, 32'h00000000);
    repeat (2) @(posedge clk);
    // A read still waiting for its compare at the end is a lost answer.
    if (exp_q.size() != 0) begin
      num_errors++;
    end
    final_report();
  end
endmodule
